// ### hw/mdiop_top.sv
// module: address/input port and bus-control port with mode-dependent pins
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
// What this block does
// - pull-up on only when pull-up bit 1, direction 0, modes 5 to 7
// - in modes 1 and 3 every address port pull-up stays off
// - pull-ups off on reset and hardware standby, held in software standby
// - pull-up control resets to f0, kept through software standby
// - modes 1 and 3: address port pins are address outputs
// - mode 5: direction 1 gives address output, 0 gives input
// - modes 6 and 7: address port pin direction follows its bit
// - modes 6 and 7: bus-control pin direction follows its bit
// - bus-control direction register is write-only, reads all ones
// - bus-control direction resets to 80, held in software standby
// - bus-control pins with direction 1 keep driving in software standby
// - bus-control data read: latch where direction 1, pin where 0
// - bus-control data bit 7 ignores writes and reads 1
// - reserved data bits 6,2,1 stored; read stored if direction 1, else 1
// - bus-control data resets to 80, held in software standby
// - modes 1, 3, 5: pins 5,4,3 are write, read, address strobes
// - expanded: pin 0 is general i/o if wait bits all 1 and mode 0
// - bus-control direction bits 7,6,2,1 are reserved, drive no pin
// - modes 1 and 3: address port drives address bits 19 to 16
// - address port direction resets to f0, held in software standby
module mdiop_top #(
  parameter int WAIT_EN_W = 8
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // operating state
  input  wire mdiop_pkg::mdiop_mode_type mode,
  input  wire logic                      hw_standby,
  input  wire logic                      sw_standby,
  // register port
  input  wire mdiop_pkg::mdiop_req_type  req,
  output      logic [7:0]                rdata,
  // bus controller side
  input  wire logic [3:0]                upper_addr,
  input  wire mdiop_pkg::mdiop_strobe_type strobes,
  output      logic                      wait_in_n,
  // address/input port pins
  input  wire logic [3:0]                addr_pin_in,
  output      logic [3:0]                addr_pin_out,
  output      logic [3:0]                addr_pin_oe,
  output      logic [3:0]                addr_pin_pullup,
  // bus-control port pins
  input  wire logic [7:0]                bus_pin_in,
  output      logic [7:0]                bus_pin_out,
  output      logic [7:0]                bus_pin_oe
);

  // ****************************************
  // decoding
  // ****************************************
  function automatic logic is_mode(input mdiop_pkg::mdiop_mode_type m, input logic [7:0] set);
    is_mode = set[m];
  endfunction : is_mode

  localparam logic [7:0] MODES_ROMLESS  = 8'h0a;
  localparam logic [7:0] MODES_EXPANDED = 8'h2a;
  localparam logic [7:0] MODES_SINGLE   = 8'hc0;
  localparam logic [7:0] MODES_PULLUP   = 8'he0;

  logic romless;
  logic expanded;
  logic single;
  logic hold;
  logic wr_hit_apdir;
  logic wr_hit_apdata;
  logic wr_hit_pcr;
  logic wr_hit_bcdir;
  logic wr_hit_bcdata;
  logic wr_hit_wait;

  assign romless  = is_mode(mode, MODES_ROMLESS);
  assign expanded = is_mode(mode, MODES_EXPANDED);
  assign single   = is_mode(mode, MODES_SINGLE);
  // software standby freezes registers and pins
  assign hold     = sw_standby;

  assign wr_hit_apdir  = req.wr && !hold && req.addr == mdiop_pkg::ADDR_PORT_DIR_OFS;
  assign wr_hit_apdata = req.wr && !hold && req.addr == mdiop_pkg::ADDR_PORT_DATA_OFS;
  assign wr_hit_pcr    = req.wr && !hold && req.addr == mdiop_pkg::PULLUP_CTRL_OFS;
  assign wr_hit_bcdir  = req.wr && !hold && req.addr == mdiop_pkg::BUS_CTRL_DIR_OFS;
  assign wr_hit_bcdata = req.wr && !hold && req.addr == mdiop_pkg::BUS_CTRL_DATA_OFS;
  assign wr_hit_wait   = req.wr && !hold && req.addr == mdiop_pkg::WAIT_CFG_OFS;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]           addr_port_direction_q;
  logic [7:0]           addr_port_data_q;
  logic [7:0]           pullup_enable_bits_q;
  logic [7:0]           bus_ctrl_port_direction_q;
  logic [7:0]           bus_ctrl_port_data_q;
  logic [WAIT_EN_W-1:0] wait_enable_bits_q;
  logic                 wait_mode_select_hi_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_port_direction_q <= mdiop_pkg::ADDR_PORT_DIR_RST;
    end else if (hw_standby) begin
      addr_port_direction_q <= mdiop_pkg::ADDR_PORT_DIR_RST;
    end else if (wr_hit_apdir) begin
      addr_port_direction_q <= req.wdata | ~mdiop_pkg::ADDR_PORT_USED_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_port_data_q <= mdiop_pkg::ADDR_PORT_DATA_RST;
    end else if (hw_standby) begin
      addr_port_data_q <= mdiop_pkg::ADDR_PORT_DATA_RST;
    end else if (wr_hit_apdata) begin
      addr_port_data_q <= req.wdata | ~mdiop_pkg::ADDR_PORT_USED_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pullup_enable_bits_q <= mdiop_pkg::PULLUP_CTRL_RST;
    end else if (hw_standby) begin
      pullup_enable_bits_q <= mdiop_pkg::PULLUP_CTRL_RST;
    end else if (wr_hit_pcr) begin
      pullup_enable_bits_q <= req.wdata | ~mdiop_pkg::ADDR_PORT_USED_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ctrl_port_direction_q <= mdiop_pkg::BUS_CTRL_DIR_RST;
    end else if (hw_standby) begin
      bus_ctrl_port_direction_q <= mdiop_pkg::BUS_CTRL_DIR_RST;
    end else if (wr_hit_bcdir) begin
      bus_ctrl_port_direction_q <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ctrl_port_data_q <= mdiop_pkg::BUS_CTRL_DATA_RST;
    end else if (hw_standby) begin
      bus_ctrl_port_data_q <= mdiop_pkg::BUS_CTRL_DATA_RST;
    end else if (wr_hit_bcdata) begin
      bus_ctrl_port_data_q <= req.wdata | mdiop_pkg::BUS_CTRL_FIXED_MASK;
    end
  end

  // wait configuration: all wait-enable bits, plus the wait-mode bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_enable_bits_q    <= '1;
      wait_mode_select_hi_q <= 1'b0;
    end else if (hw_standby) begin
      wait_enable_bits_q    <= '1;
      wait_mode_select_hi_q <= 1'b0;
    end else if (wr_hit_wait) begin
      wait_enable_bits_q    <= {WAIT_EN_W{req.wdata[0]}};
      wait_mode_select_hi_q <= req.wdata[mdiop_pkg::WAIT_MODE_BIT];
    end
  end

  // ****************************************
  // pin functions
  // ****************************************
  logic       pin0_is_gpio;
  logic [3:0] ap_out_d;
  logic [3:0] ap_oe_d;
  logic [3:0] ap_pu_d;
  logic [7:0] bc_out_d;
  logic [7:0] bc_oe_d;

  assign pin0_is_gpio = (&wait_enable_bits_q) && !wait_mode_select_hi_q;

  always_comb begin
    ap_out_d = addr_port_data_q[3:0];
    ap_oe_d  = addr_port_direction_q[3:0];
    if (romless) begin
      ap_out_d = upper_addr;
      ap_oe_d  = 4'hf;
    end else if (mode == mdiop_pkg::MODE_5) begin
      ap_out_d = upper_addr;
      ap_oe_d  = addr_port_direction_q[3:0];
    end else if (!single) begin
      ap_oe_d  = 4'h0;
    end
  end

  // pull-ups only in modes 5 to 7 on input pins
  always_comb begin
    if (is_mode(mode, MODES_PULLUP)) begin
      ap_pu_d = pullup_enable_bits_q[3:0] & ~addr_port_direction_q[3:0];
    end else begin
      ap_pu_d = 4'h0;
    end
  end

  always_comb begin
    bc_out_d = bus_ctrl_port_data_q & mdiop_pkg::BUS_CTRL_PIN_MASK;
    bc_oe_d  = bus_ctrl_port_direction_q & mdiop_pkg::BUS_CTRL_PIN_MASK;
    if (expanded) begin
      bc_out_d[mdiop_pkg::WR_PIN] = strobes.write_strobe_n;
      bc_out_d[mdiop_pkg::RD_PIN] = strobes.read_strobe_n;
      bc_out_d[mdiop_pkg::AS_PIN] = strobes.address_strobe_n;
      bc_oe_d[mdiop_pkg::WR_PIN]  = 1'b1;
      bc_oe_d[mdiop_pkg::RD_PIN]  = 1'b1;
      bc_oe_d[mdiop_pkg::AS_PIN]  = 1'b1;
      // as wait input the pin is never driven; software keeps its bit 0
      if (!pin0_is_gpio) begin
        bc_oe_d[mdiop_pkg::WAIT_PIN] = 1'b0;
      end
    end else if (!single) begin
      bc_oe_d = 8'h00;
    end
  end

  // pins frozen in software standby, pull-ups off in reset and hw standby
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_pin_out    <= 4'h0;
      addr_pin_oe     <= 4'h0;
      addr_pin_pullup <= 4'h0;
      bus_pin_out     <= 8'h00;
      bus_pin_oe      <= 8'h00;
    end else if (hw_standby) begin
      addr_pin_out    <= 4'h0;
      addr_pin_oe     <= 4'h0;
      addr_pin_pullup <= 4'h0;
      bus_pin_out     <= 8'h00;
      bus_pin_oe      <= 8'h00;
    end else if (!hold) begin
      addr_pin_out    <= ap_out_d;
      addr_pin_oe     <= ap_oe_d;
      addr_pin_pullup <= ap_pu_d;
      bus_pin_out     <= bc_out_d;
      bus_pin_oe      <= bc_oe_d;
    end
  end

  // wait input passed to the bus controller, high when not selected
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_in_n <= 1'b1;
    end else begin
      wait_in_n <= (expanded && !pin0_is_gpio) ? bus_pin_in[mdiop_pkg::WAIT_PIN] : 1'b1;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rdata_d;
  logic [7:0] bc_read;
  logic [7:0] ap_read;

  assign bc_read = mdiop_pkg::BUS_CTRL_FIXED_MASK
                 | (((bus_ctrl_port_direction_q & bus_ctrl_port_data_q)
                     | (~bus_ctrl_port_direction_q & bus_pin_in))
                    & mdiop_pkg::BUS_CTRL_PIN_MASK)
                 | (mdiop_pkg::BUS_CTRL_STORE_MASK
                    & (~bus_ctrl_port_direction_q | bus_ctrl_port_data_q));
  assign ap_read = ~mdiop_pkg::ADDR_PORT_USED_MASK
                 | (addr_port_direction_q & addr_port_data_q)
                 | (~addr_port_direction_q & {4'h0, addr_pin_in});

  always_comb begin
    rdata_d = 8'h00;
    unique case (req.addr)
      mdiop_pkg::ADDR_PORT_DIR_OFS:  rdata_d = mdiop_pkg::READ_ALL_ONES;
      mdiop_pkg::BUS_CTRL_DIR_OFS:   rdata_d = mdiop_pkg::READ_ALL_ONES;
      mdiop_pkg::ADDR_PORT_DATA_OFS: rdata_d = ap_read;
      mdiop_pkg::BUS_CTRL_DATA_OFS:  rdata_d = bc_read;
      mdiop_pkg::PULLUP_CTRL_OFS:    rdata_d = pullup_enable_bits_q;
      mdiop_pkg::WAIT_CFG_OFS:       rdata_d = {3'h0, wait_mode_select_hi_q, 3'h0,
                                                &wait_enable_bits_q};
      mdiop_pkg::MODE_STAT_OFS:      rdata_d = {3'h0, pin0_is_gpio, 1'b0, mode};
      default:                       rdata_d = 8'h00;
    endcase
  end

  // data stands in the cycle after the read strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : mdiop_top

// ### hw/mdiop_pkg.sv
// package: register map, resets and types of the mode-dependent i/o ports
package mdiop_pkg;

  // ****************************************
  // register offsets (lower 16 address bits)
  // ****************************************
  localparam logic [15:0] ADDR_PORT_DIR_OFS    = 16'hffc8;
  localparam logic [15:0] BUS_CTRL_DIR_OFS     = 16'hffc9;
  localparam logic [15:0] ADDR_PORT_DATA_OFS   = 16'hffca;
  localparam logic [15:0] BUS_CTRL_DATA_OFS    = 16'hffcb;
  localparam logic [15:0] PULLUP_CTRL_OFS      = 16'hffdb;
  localparam logic [15:0] WAIT_CFG_OFS         = 16'hffe0;
  localparam logic [15:0] MODE_STAT_OFS        = 16'hffe1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] ADDR_PORT_DIR_RST     = 8'hf0;
  localparam logic [7:0] ADDR_PORT_DATA_RST    = 8'hf0;
  localparam logic [7:0] PULLUP_CTRL_RST       = 8'hf0;
  localparam logic [7:0] BUS_CTRL_DIR_RST      = 8'h80;
  localparam logic [7:0] BUS_CTRL_DATA_RST     = 8'h80;
  localparam logic [7:0] WAIT_CFG_RST          = 8'h00;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam logic [7:0] ADDR_PORT_USED_MASK   = 8'h0f;
  localparam logic [7:0] BUS_CTRL_PIN_MASK     = 8'h39;
  localparam logic [7:0] BUS_CTRL_STORE_MASK   = 8'h46;
  localparam logic [7:0] BUS_CTRL_FIXED_MASK   = 8'h80;
  localparam logic [7:0] READ_ALL_ONES         = 8'hff;
  localparam int         WR_PIN                = 5;
  localparam int         RD_PIN                = 4;
  localparam int         AS_PIN                = 3;
  localparam int         WAIT_PIN              = 0;
  localparam int         WAIT_MODE_BIT         = 4;

  // operating mode code on the mode pins
  typedef enum logic [2:0] {
    MODE_0 = 3'h0, MODE_1 = 3'h1, MODE_2 = 3'h2, MODE_3 = 3'h3,
    MODE_4 = 3'h4, MODE_5 = 3'h5, MODE_6 = 3'h6, MODE_7 = 3'h7
  } mdiop_mode_type;

  // bus strobes from the bus controller, active low
  typedef struct packed {
    logic write_strobe_n;
    logic read_strobe_n;
    logic address_strobe_n;
  } mdiop_strobe_type;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } mdiop_req_type;

endpackage : mdiop_pkg

// ### dv/mdiop_props.sv
// checker: concurrent properties of the mode-dependent i/o ports
`timescale 1ns/100ps
module mdiop_props (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rstn,
  // operating state and register port
  input wire mdiop_pkg::mdiop_mode_type   mode,
  input wire logic                        hw_standby,
  input wire logic                        sw_standby,
  input wire mdiop_pkg::mdiop_req_type    req,
  input wire logic [7:0]                  rdata,
  // bus controller side
  input wire logic [3:0]                  upper_addr,
  input wire mdiop_pkg::mdiop_strobe_type strobes,
  // pins
  input wire logic [3:0]                  addr_pin_oe,
  input wire logic [3:0]                  addr_pin_out,
  input wire logic [3:0]                  addr_pin_pullup,
  input wire logic [7:0]                  bus_pin_out,
  input wire logic [7:0]                  bus_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic run;
  logic ext13;
  logic ext135;
  assign run    = !hw_standby && !sw_standby;
  assign ext13  = (mode == mdiop_pkg::MODE_1) || (mode == mdiop_pkg::MODE_3);
  assign ext135 = ext13 || (mode == mdiop_pkg::MODE_5);
  sequence s_sw_held;
    (sw_standby && !hw_standby) [*2];
  endsequence
  sequence s_dir_read;
    req.rd && (req.addr == mdiop_pkg::BUS_CTRL_DIR_OFS);
  endsequence
  a_pullup_off_exp: assert property (ext13 |-> addr_pin_pullup == 4'h0)
    else $error("pull-up on in modes 1 or 3");
  a_pullup_input_only: assert property ((addr_pin_pullup & addr_pin_oe) == 4'h0)
    else $error("pull-up on a driven pin");
  a_addr_bits_out: assert property (rstn && ext13 && run |=>
    addr_pin_oe == 4'hf && addr_pin_out == $past(upper_addr)) else $error("upper address not out");
  a_strobe_pins_out: assert property (rstn && ext135 && run |=>
    bus_pin_oe[5:3] == 3'h7 && bus_pin_out[5:3] == $past(strobes)) else $error("strobes not out");
  a_dir_reads_ones: assert property (s_dir_read |=> rdata == 8'hff)
    else $error("direction read not all ones");
  a_bit7_reads_one: assert property (req.rd && req.addr == mdiop_pkg::BUS_CTRL_DATA_OFS
    |=> rdata[7] == 1'b1) else $error("data bit 7 not one");
  a_hw_pullup_off: assert property (hw_standby |=> addr_pin_pullup == 4'h0)
    else $error("pull-up on after hardware standby");
  a_sw_pins_held: assert property (s_sw_held |-> $stable(addr_pin_pullup) &&
    $stable(addr_pin_oe) && $stable(bus_pin_oe)) else $error("pins moved in software standby");
endmodule : mdiop_props

bind mdiop_top mdiop_props u_props (.clk(clk), .rstn(rstn), .mode(mode),
  .hw_standby(hw_standby), .sw_standby(sw_standby), .req(req), .rdata(rdata),
  .upper_addr(upper_addr), .strobes(strobes), .addr_pin_oe(addr_pin_oe),
  .addr_pin_out(addr_pin_out), .addr_pin_pullup(addr_pin_pullup),
  .bus_pin_out(bus_pin_out), .bus_pin_oe(bus_pin_oe));

// ### dv/mdiop_pin_load.sv
// partner: board loads that settle the level seen on each port pin
`timescale 1ns/100ps
module mdiop_pin_load (
  // address/input port
  input  wire logic [3:0] addr_out,
  input  wire logic [3:0] addr_oe,
  input  wire logic [3:0] addr_pullup,
  input  wire logic [3:0] addr_ext,
  output      logic [3:0] addr_level,
  // bus-control port
  input  wire logic [7:0] bus_out,
  input  wire logic [7:0] bus_oe,
  input  wire logic [7:0] bus_ext,
  output      logic [7:0] bus_level
);
  // driven pin wins, then pull-up, then the board's own level
  assign addr_level = (addr_oe & addr_out) | (~addr_oe & (addr_pullup | addr_ext));
  assign bus_level  = (bus_oe & bus_out) | (~bus_oe & bus_ext);
endmodule : mdiop_pin_load

// ### dv/testbench.sv
// testbench: register and pin checks of the mode-dependent i/o ports
`timescale 1ns/100ps
module testbench;
  logic                        clk = 1'b0;
  logic                        rstn = 1'b0;
  mdiop_pkg::mdiop_mode_type   mode = mdiop_pkg::MODE_7;
  logic                        hw_standby = 1'b0;
  logic                        sw_standby = 1'b0;
  mdiop_pkg::mdiop_req_type    req = '0;
  mdiop_pkg::mdiop_strobe_type strobes = 3'h7;
  logic [3:0]                  upper_addr = 4'h0;
  logic [3:0]                  addr_ext = 4'h0;
  logic [7:0]                  bus_ext = 8'h00;
  logic [7:0]                  rdata, bus_pin_in, bus_pin_out, bus_pin_oe;
  logic [3:0]                  addr_pin_in, addr_pin_out, addr_pin_oe, addr_pin_pullup;
  logic                        wait_in_n;
  int                          bad_count = 0;
  int                          checked = 0;
  int                          cycles = 0;
  always #5 clk = ~clk;
  mdiop_top uut (.clk(clk), .rstn(rstn), .mode(mode), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .req(req), .rdata(rdata), .upper_addr(upper_addr),
    .strobes(strobes), .wait_in_n(wait_in_n), .addr_pin_in(addr_pin_in),
    .addr_pin_out(addr_pin_out), .addr_pin_oe(addr_pin_oe), .addr_pin_pullup(addr_pin_pullup),
    .bus_pin_in(bus_pin_in), .bus_pin_out(bus_pin_out), .bus_pin_oe(bus_pin_oe));
  mdiop_pin_load u_load (.addr_out(addr_pin_out), .addr_oe(addr_pin_oe),
    .addr_pullup(addr_pin_pullup), .addr_ext(addr_ext), .addr_level(addr_pin_in),
    .bus_out(bus_pin_out), .bus_oe(bus_pin_oe), .bus_ext(bus_ext), .bus_level(bus_pin_in));
  // ****************************************
  // tasks
  // ****************************************
  task automatic complete_run;
    $display("counts: %0d compared, %0d wrong", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic restart(input mdiop_pkg::mdiop_mode_type m);
    @(posedge clk);
    rstn <= 1'b0;
    mode <= m;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
  endtask : restart
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    restart(mdiop_pkg::MODE_7);
    rd(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'hff);
    rd(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'hc6);
    rd(mdiop_pkg::PULLUP_CTRL_OFS, 8'hf0);
    rd(16'hffc0, 8'h00);
    check(8'(addr_pin_oe), 8'h00);
    check(8'(addr_pin_pullup), 8'h00);
    $display("test reset values done");
    wr(mdiop_pkg::PULLUP_CTRL_OFS, 8'h0f);
    wr(mdiop_pkg::ADDR_PORT_DIR_OFS, 8'h05);
    settle();
    check(8'(addr_pin_pullup), 8'h0a);
    check(8'(addr_pin_oe), 8'h05);
    $display("test pull-ups done");
    wr(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'hff);
    wr(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'h29);
    settle();
    check(bus_pin_oe, 8'h39);
    check(bus_pin_out & 8'h39, 8'h29);
    rd(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'ha9);
    @(posedge clk);
    sw_standby <= 1'b1;
    wr(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'h00);
    wr(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'h00);
    settle();
    check(bus_pin_oe, 8'h39);
    sw_standby <= 1'b0;
    rd(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'ha9);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clk);
    hw_standby <= 1'b0;
    rd(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'hc6);
    rd(mdiop_pkg::PULLUP_CTRL_OFS, 8'hf0);
    check(8'(addr_pin_oe), 8'h00);
    wr(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'hff);
    wr(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'h42);
    rd(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'hc2);
    bus_ext <= 8'h10;
    wr(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'h00);
    settle();
    rd(mdiop_pkg::BUS_CTRL_DATA_OFS, 8'hd6);
    $display("test bus-control port done");
    restart(mdiop_pkg::MODE_1);
    upper_addr <= 4'ha;
    strobes <= 3'h5;
    wr(mdiop_pkg::PULLUP_CTRL_OFS, 8'h0f);
    wr(mdiop_pkg::ADDR_PORT_DIR_OFS, 8'h00);
    settle();
    check(8'(addr_pin_oe), 8'h0f);
    check(8'(addr_pin_out), 8'h0a);
    check(8'(addr_pin_pullup), 8'h00);
    check(bus_pin_oe & 8'h38, 8'h38);
    check(bus_pin_out & 8'h38, 8'h28);
    check(8'(wait_in_n), 8'h01);
    $display("test mode 1 done");
    restart(mdiop_pkg::MODE_5);
    upper_addr <= 4'h6;
    settle();
    check(8'(addr_pin_oe), 8'h00);
    wr(mdiop_pkg::ADDR_PORT_DIR_OFS, 8'h03);
    wr(mdiop_pkg::PULLUP_CTRL_OFS, 8'h0f);
    wr(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'h01);
    settle();
    check(8'(addr_pin_oe), 8'h03);
    check(8'(addr_pin_out & 4'h3), 8'h02);
    check(8'(addr_pin_pullup), 8'h0c);
    check(bus_pin_oe & 8'h39, 8'h39);
    wr(mdiop_pkg::BUS_CTRL_DIR_OFS, 8'h00);
    wr(mdiop_pkg::WAIT_CFG_OFS, 8'h11);
    bus_ext <= 8'h00;
    settle();
    check(8'(wait_in_n), 8'h00);
    bus_ext <= 8'h01;
    settle();
    check(8'(wait_in_n), 8'h01);
    $display("test mode 5 done");
    complete_run();
  end
endmodule : testbench
